// [host_model.sv]
`timescale 1ns/1ns

module host_model #(
	parameter int WORD_W = 20
) (
	output logic sclk,
	output logic serial_data,
	output logic load_strobe
);
	initial begin
		sclk = 1'h0;
		serial_data = 1'h0;
		load_strobe = 1'h0;
	end

	// The serial clock runs only inside a frame and rests low.
	task automatic send(input logic [WORD_W-1:0] w);
		for (int i = WORD_W - 1; i >= 0; i--) begin
			serial_data = w[i];
			#32 sclk = 1'h1;
			#32 sclk = 1'h0;
		end
		// A released data line must not keep showing the last bit.
		serial_data = ~serial_data;
		#100 load_strobe = 1'h1;
		#800 load_strobe = 1'h0;
		#300;
	endtask : send
endmodule : host_model

// [serial_latch_load_interface.sv]
`timescale 1ns/1ns
`include "serial_latch_map.svh"

// How it works
// - Serial words arrive most significant bit first.
// - Last bit picks the destination latch.
// - Strobe rising edge copies word into latch.
// - Low polarity select reverses pump direction.
// - Strobe high routes pump onto bypass pin.
// - VCO comparator input is shown on monitor pin.
// - One bit shifted per rising serial clock.

module serial_latch_load_interface #(
	parameter int WORD_W = `WORD_W
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic ce,
	input wire logic sclk,
	input wire logic serial_data,
	input wire logic load_strobe,
	input wire logic phase_polarity_select,
	input wire logic ref_in,
	input wire logic vco_in,
	output logic [WORD_W-2:0] ref_latch,
	output logic [WORD_W-2:0] main_latch,
	output logic load_pulse,
	output logic pump_out,
	output logic pump_oe,
	output logic bypass_switch_out,
	output logic bypass_switch_oe,
	output logic monitor_out
);

	////////////////////////////////////////////////////////////////////////////////
	// Serial side, clocked by the host's serial clock.

	logic [WORD_W-1:0] shift_word;

	serial_shifter #(
		.WIDTH(WORD_W)
	) shifter (
		.sclk(sclk),
		.rst_n(rst_n),
		.serial_data(serial_data),
		.word(shift_word)
	);

	////////////////////////////////////////////////////////////////////////////////
	// Pin synchronisers on the system clock.

	logic strobe_meta;
	logic strobe_sync;
	logic strobe_prev;
	logic pol_meta;
	logic pol_sync;
	logic ref_meta;
	logic ref_sync;
	logic ref_prev;
	logic vco_meta;
	logic vco_sync;
	logic vco_prev;

	// The pull-ups on the strobe and polarity pins are modelled by resetting high.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			strobe_meta <= 1'h1;
			strobe_sync <= 1'h1;
			strobe_prev <= 1'h1;
			pol_meta <= 1'h1;
			pol_sync <= 1'h1;
		end else if (ce) begin
			strobe_meta <= load_strobe;
			strobe_sync <= strobe_meta;
			strobe_prev <= strobe_sync;
			pol_meta <= phase_polarity_select;
			pol_sync <= pol_meta;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			ref_meta <= 1'h0;
			ref_sync <= 1'h0;
			ref_prev <= 1'h0;
			vco_meta <= 1'h0;
			vco_sync <= 1'h0;
			vco_prev <= 1'h0;
		end else if (ce) begin
			ref_meta <= ref_in;
			ref_sync <= ref_meta;
			ref_prev <= ref_sync;
			vco_meta <= vco_in;
			vco_sync <= vco_meta;
			vco_prev <= vco_sync;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Load path.

	// The shift word crosses domains unsynchronised on purpose: it is only
	// sampled on a synchronised strobe edge, and the host keeps the serial
	// clock still while the strobe moves, so the word is quiet by then.
	wire strobe_rise = strobe_sync & ~strobe_prev;
	wire ctrl_bit = shift_word[`CTRL_POS];
	wire [WORD_W-2:0] word_payload = shift_word[WORD_W-1:1];
	wire load_ref = strobe_rise & (ctrl_bit == `CTRL_REF);
	wire load_main = strobe_rise & (ctrl_bit == `CTRL_MAIN);
	wire [WORD_W-2:0] next_ref_latch = load_ref ? word_payload : ref_latch;
	wire [WORD_W-2:0] next_main_latch = load_main ? word_payload : main_latch;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			ref_latch <= `LATCH_RST;
			main_latch <= `LATCH_RST;
			load_pulse <= 1'h0;
		end else if (ce) begin
			ref_latch <= next_ref_latch;
			main_latch <= next_main_latch;
			load_pulse <= strobe_rise;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Phase comparator and charge pump direction.

	serial_latch_pkg::pump_state_t pump_state;
	serial_latch_pkg::pump_state_t next_pump_state;

	wire ref_edge = ref_sync & ~ref_prev;
	wire vco_edge = vco_sync & ~vco_prev;
	// A low polarity select swaps which input drives the pump up.
	wire up_event = pol_sync ? ref_edge : vco_edge;
	wire down_event = pol_sync ? vco_edge : ref_edge;

	always_comb begin
		next_pump_state = pump_state;
		unique case (pump_state)
			serial_latch_pkg::PUMP_OFF: begin
				if (up_event && !down_event) begin
					next_pump_state = serial_latch_pkg::PUMP_SOURCE;
				end else if (down_event && !up_event) begin
					next_pump_state = serial_latch_pkg::PUMP_SINK;
				end
			end
			serial_latch_pkg::PUMP_SOURCE: begin
				if (down_event) begin
					next_pump_state = serial_latch_pkg::PUMP_OFF;
				end
			end
			serial_latch_pkg::PUMP_SINK: begin
				if (up_event) begin
					next_pump_state = serial_latch_pkg::PUMP_OFF;
				end
			end
			default: begin
				next_pump_state = serial_latch_pkg::PUMP_OFF;
			end
		endcase
	end

	wire next_pump_out = (next_pump_state == serial_latch_pkg::PUMP_SOURCE);
	wire next_pump_oe = (next_pump_state != serial_latch_pkg::PUMP_OFF);
	// The switch follows the synchronised strobe, so it closes three cycles late.
	wire next_bypass_oe = next_pump_oe & strobe_sync;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			pump_state <= serial_latch_pkg::PUMP_OFF;
			pump_out <= 1'h0;
			pump_oe <= 1'h0;
			bypass_switch_out <= 1'h0;
			bypass_switch_oe <= 1'h0;
			monitor_out <= 1'h0;
		end else if (ce) begin
			pump_state <= next_pump_state;
			pump_out <= next_pump_out;
			pump_oe <= next_pump_oe;
			bypass_switch_out <= next_pump_out;
			bypass_switch_oe <= next_bypass_oe;
			monitor_out <= vco_sync;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Checks.

	default clocking cb @(posedge clk);
	endclocking

	default disable iff (!rst_n);

	ref_load_a: assert property (
		ce && strobe_rise && shift_word[0] == 1'h0 |=> ref_latch == $past(word_payload))
		else $error("Reference latch missed a strobe load.");

	main_load_a: assert property (
		ce && strobe_rise && shift_word[0] == 1'h1 |=> main_latch == $past(word_payload))
		else $error("Main latch missed a strobe load.");

	latch_hold_a: assert property (
		!(ce && strobe_rise) |=> $stable(ref_latch) && $stable(main_latch))
		else $error("A latch changed without a strobe edge.");

	pump_normal_a: assert property (
		ce && pol_sync && ref_edge && !vco_edge
		&& pump_state == serial_latch_pkg::PUMP_OFF |=> pump_oe && pump_out)
		else $error("Normal polarity did not source on reference lead.");

	pump_reversed_a: assert property (
		ce && !pol_sync && ref_edge && !vco_edge
		&& pump_state == serial_latch_pkg::PUMP_OFF |=> pump_oe && !pump_out)
		else $error("Reversed polarity did not sink on reference lead.");

	bypass_route_a: assert property (
		ce |=> bypass_switch_oe == ($past(strobe_sync) && pump_oe)
		&& bypass_switch_out == pump_out)
		else $error("Bypass switch does not follow strobe and pump.");

	monitor_pin_a: assert property (
		ce ##1 ce |=> monitor_out == $past(vco_sync) && $past(monitor_out) == $past(vco_sync, 2))
		else $error("Monitor output does not track comparator input.");

	strobe_pulse_a: assert property (
		ce && strobe_rise |=> load_pulse ##1 (!load_pulse || !$past(ce)))
		else $error("Load pulse missing or too long.");

	// The strobe edge is only seen two flops deep, so the chain must move each cycle.
	strobe_chain_a: assert property (
		ce |=> strobe_sync == $past(strobe_meta))
		else $error("Strobe synchroniser skipped a stage.");

	pulse_quiet_a: assert property (
		ce && !strobe_rise |=> !load_pulse)
		else $error("Load pulse without a strobe edge.");

	// A frozen block must not lose or invent a load while the enable is low.
	freeze_hold_a: assert property (
		!ce |=> $stable(ref_latch) && $stable(main_latch) && $stable(load_pulse))
		else $error("State moved while the clock enable was low.");

	bypass_open_a: assert property (
		ce && !strobe_sync |=> !bypass_switch_oe)
		else $error("Bypass switch closed with the strobe low.");

	pump_idle_a: assert property (
		ce && pump_state == serial_latch_pkg::PUMP_OFF && !up_event && !down_event
		|=> !pump_oe)
		else $error("Pump drove with no comparator edge.");

	source_stop_a: assert property (
		ce && pump_state == serial_latch_pkg::PUMP_SOURCE && down_event |=> !pump_oe)
		else $error("Sourcing pump did not stop on the opposite edge.");

	sink_stop_a: assert property (
		ce && pump_state == serial_latch_pkg::PUMP_SINK && up_event |=> !pump_oe)
		else $error("Sinking pump did not stop on the opposite edge.");

	ref_load_c: cover property (ce && load_ref);
	main_load_c: cover property (ce && load_main);
	reversed_pump_c: cover property (!pol_sync && pump_oe && !pump_out);
	bypass_on_c: cover property (bypass_switch_oe);
	pol_flip_c: cover property ($fell(pol_sync));

endmodule : serial_latch_load_interface

// [serial_latch_map.svh]
`ifndef SERIAL_LATCH_MAP_SVH
`define SERIAL_LATCH_MAP_SVH

// Serial word length in bits, control bit included.
`define WORD_W 20
// Position of the control bit inside the shifted word.
`define CTRL_POS 0
// Control bit values that pick the destination latch.
`define CTRL_REF 1'h0
`define CTRL_MAIN 1'h1
// Reset values of the shift register and of both latches.
`define SHIFT_RST 20'h00000
`define LATCH_RST 19'h00000

`endif

// [serial_latch_pkg.sv]
package serial_latch_pkg;

	typedef enum logic [2:0] {
		PUMP_OFF = 3'h1,
		PUMP_SOURCE = 3'h2,
		PUMP_SINK = 3'h4
	} pump_state_t;

	typedef enum logic {
		LATCH_REF = 1'h0,
		LATCH_MAIN = 1'h1
	} latch_sel_t;

endpackage : serial_latch_pkg

// [serial_shifter.sv]
`timescale 1ns/1ns
`include "serial_latch_map.svh"

module serial_shifter #(
	parameter int WIDTH = `WORD_W
) (
	input wire logic sclk,
	input wire logic rst_n,
	input wire logic serial_data,
	output logic [WIDTH-1:0] word
);

	wire [WIDTH-1:0] next_word = {word[WIDTH-2:0], serial_data};

	// The first bit entered travels to the top, so the word arrives MSB first.
	always_ff @(posedge sclk or negedge rst_n) begin
		if (!rst_n) begin
			word <= `SHIFT_RST;
		end else begin
			word <= next_word;
		end
	end

	////////////////////////////////////////////////////////////////////////////////

	shift_in_a: assert property (@(posedge sclk) disable iff (!rst_n)
		##1 word[0] == $past(serial_data))
		else $error("Serial bit not taken on the rising serial clock.");

	shift_order_a: assert property (@(posedge sclk) disable iff (!rst_n)
		##1 word[WIDTH-1:1] == $past(word[WIDTH-2:0]))
		else $error("Shift register did not move toward the top bit.");

endmodule : serial_shifter

// [tb_top.sv]
`timescale 1ns/1ns

module tb_top;
	logic clk = 1'h0;
	logic rst_n = 1'h0;
	logic ce = 1'h1;
	logic ppol = 1'h1;
	logic ref_in = 1'h0;
	logic vco_in = 1'h0;
	wire sclk, sdat, strobe;
	logic [18:0] ref_latch, main_latch;
	logic load_pulse, pump_out, pump_oe, bsw_out, bsw_oe, monitor_out;
	logic [18:0] ref_exp = 19'h00000;
	logic [18:0] main_exp = 19'h00000;
	logic [37:0] q[$];
	int n_fail = 0;
	int total_checks = 0;

	always #50 clk = ~clk;

	host_model #(.WORD_W(20)) u_host (.sclk(sclk), .serial_data(sdat), .load_strobe(strobe));

	serial_latch_load_interface #(.WORD_W(20)) u_dut (.clk(clk), .rst_n(rst_n), .ce(ce),
		.sclk(sclk), .serial_data(sdat), .load_strobe(strobe), .phase_polarity_select(ppol),
		.ref_in(ref_in), .vco_in(vco_in), .ref_latch(ref_latch), .main_latch(main_latch),
		.load_pulse(load_pulse), .pump_out(pump_out), .pump_oe(pump_oe),
		.bypass_switch_out(bsw_out), .bypass_switch_oe(bsw_oe), .monitor_out(monitor_out));

	////////////////////////////////////////////////////////////////////////////////
	task automatic chk(input string nm, input logic [37:0] seen, input logic [37:0] exp);
		total_checks++;
		if (seen !== exp) begin
			n_fail++;
			$display("[ERR] %s expected %h seen %h", nm, exp, seen);
		end
	endtask : chk

	task automatic summarize();
		$display("checks %0d mismatches %0d", total_checks, n_fail);
		if (n_fail == 0 && total_checks > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask : summarize

	task automatic load_word(input logic ctrl);
		logic [19:0] w;
		w = 20'($urandom());
		w[0] = ctrl;
		if (ctrl) main_exp = w[19:1];
		else ref_exp = w[19:1];
		q.push_back({ref_exp, main_exp});
		u_host.send(w);
	endtask : load_word

	////////////////////////////////////////////////////////////////////////////////
	// Outputs are sampled on the falling edge, where the design's updates have landed.
	always @(negedge clk) begin
		logic [37:0] e;
		if (load_pulse === 1'h1) begin
			e = (q.size() > 0) ? q.pop_front() : 38'h0;
			chk("ref_latch", 38'(ref_latch), 38'(e[37:19]));
			chk("main_latch", 38'(main_latch), 38'(e[18:0]));
			chk("bypass_oe", 38'(bsw_oe), 38'(pump_oe));
			chk("bypass_out", 38'(bsw_out), 38'(pump_out));
		end
	end

	initial begin
		#300000;
		n_fail++;
		summarize();
	end

	initial begin
		void'($urandom(88384));
		repeat (8) @(posedge clk);
		rst_n <= 1'h1;
		repeat (2) @(posedge clk);
		for (int i = 0; i < 6; i++) load_word(i[0]);
		for (int p = 1; p >= 0; p--) begin
			@(posedge clk);
			ppol <= p[0];
			repeat (4) @(posedge clk);
			ref_in <= 1'h1;
			repeat (5) @(negedge clk);
			chk("pump_oe", 38'(pump_oe), 38'h1);
			chk("pump_out", 38'(pump_out), 38'(p[0]));
			load_word(p[0]);
			@(posedge clk);
			vco_in <= 1'h1;
			repeat (5) @(negedge clk);
			chk("pump_off", 38'(pump_oe), 38'h0);
			chk("monitor_hi", 38'(monitor_out), 38'h1);
			@(posedge clk);
			ref_in <= 1'h0;
			vco_in <= 1'h0;
			repeat (5) @(negedge clk);
			chk("monitor_lo", 38'(monitor_out), 38'h0);
		end
		@(posedge clk);
		ce <= 1'h0;
		ref_in <= 1'h1;
		repeat (5) @(negedge clk);
		chk("frozen_pump", 38'(pump_oe), 38'h0);
		@(posedge clk);
		ce <= 1'h1;
		repeat (5) @(negedge clk);
		chk("thawed_oe", 38'(pump_oe), 38'h1);
		chk("thawed_out", 38'(pump_out), 38'h0);
		@(posedge clk);
		vco_in <= 1'h1;
		repeat (5) @(negedge clk);
		chk("thawed_off", 38'(pump_oe), 38'h0);
		repeat (10) @(posedge clk);
		chk("loads_left", 38'(q.size()), 38'h0);
		summarize();
	end
endmodule : tb_top
